// >>> gpc_pkg.sv
// Package for the GPIO pin configuration and external interrupt block.
// Assumes AXI4-Lite byte addresses of four times the register index.
package gpc_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_PORT0_VALUE = 6'h00;
  localparam logic [5:0] IDX_PORT1_VALUE = 6'h01;
  localparam logic [5:0] IDX_PORT3_VALUE = 6'h03;
  localparam logic [5:0] IDX_PORT4_VALUE = 6'h04;
  localparam logic [5:0] IDX_EXT_IRQ_A_CFG = 6'h07;
  localparam logic [5:0] IDX_EXT_IRQ_B_CFG = 6'h08;
  localparam logic [5:0] IDX_EXT_IRQ_C_CFG = 6'h09;
  localparam logic [5:0] IDX_PORT1_PIN0_CFG = 6'h0d;
  localparam logic [5:0] IDX_PORT1_PIN1_CFG = 6'h0e;
  localparam logic [5:0] IDX_PORT1_PIN2_CFG = 6'h0f;
  localparam logic [5:0] IDX_SLAVE_SELECT_CFG = 6'h10;
  localparam logic [5:0] IDX_PORT3_GROUP_CFG = 6'h16;
  localparam logic [5:0] IDX_PORT4_GROUP_CFG = 6'h17;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
  // Configuration slots
  localparam int NCFG = 9;
  localparam int SLOT_P1 = 3;
  localparam int SLOT_P3 = 7;
  localparam int SLOT_P4 = 8;
  // Writable bits of each configuration byte
  localparam logic [7:0] WMASK_EXT = 8'h37;
  localparam logic [7:0] WMASK_P10 = 8'h77;
  localparam logic [7:0] WMASK_P11 = 8'h65;
  localparam logic [7:0] WMASK_P12 = 8'hf7;
  localparam logic [7:0] WMASK_P13 = 8'h6f;
  localparam logic [7:0] WMASK_GRP = 8'h7f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Configuration field positions
  localparam int B_OE = 0;
  localparam int B_PU = 1;
  localparam int B_OD = 2;
  localparam int B_HS = 3;
  localparam int B_TTL = 4;
  localparam int B_ACT_LOW = 5;
  localparam int B_IE = 6;
  localparam int B_CLKO = 7;
  // Flattened pin numbering
  localparam int NPIN = 19;
  localparam int PIN_P0 = 0;
  localparam int PIN_P1 = 3;
  localparam int PIN_P3 = 7;
  localparam int PIN_P4 = 15;
  localparam int PIN_CLKO = 5;
  localparam int PIN_SSEL = 6;
  localparam int PIN_P3_SMALL_END = 9;
  localparam int PIN_P3_HS = 14;
  // Interrupt status bits
  localparam int NIRQ = 6;
  localparam int ST_EXT = 0;
  localparam int ST_P1 = 3;
  localparam int ST_P3 = 4;
  localparam int ST_P4 = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

// >>> gpc_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module gpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } gpc_sync_state_type;

  gpc_sync_state_type st_r;
  gpc_sync_state_type st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule
`default_nettype wire

// >>> gpc_edge.sv
// Per-bit active-edge detector with selectable polarity.
// Assumes level inputs already synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module gpc_edge #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] act_low,
  output logic [WIDTH-1:0] hit
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } gpc_edge_state_type;

  gpc_edge_state_type st_r;
  gpc_edge_state_type st_nxt;
  logic [WIDTH-1:0] norm;

  // Polarity applied before comparing, so a polarity flip can look like an edge
  always_comb begin
    norm = level ^ act_low;
    st_nxt = st_r;
    st_nxt.prev = norm;
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Rising of the normalised level
  assign hit = norm & ~st_r.prev;
endmodule
`default_nettype wire

// >>> gpc_top.sv
// GPIO pin configuration with three dedicated edge interrupt pins,
// AXI4-Lite register access, sticky interrupt status and mask.
// Assumes pad inputs synchronous-free levels; pad wiring resolves oe/pull-up.
`timescale 1ns/10ps
`default_nettype none
module gpc_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [18:0] pad_i,
  input wire logic clk_sel_i,
  output logic [18:0] pad_o,
  output logic [18:0] pad_oe,
  output logic [18:0] pad_pullup,
  output logic [18:0] pad_ttl,
  output logic [18:0] pad_high_sink,
  output logic [2:0] ext_irq_req,
  output logic [2:0] port_irq_req,
  output logic irq
);
  typedef struct packed {
    logic [gpc_pkg::NCFG-1:0][7:0] cfg;
    logic [3:0][7:0] dat;
    logic [gpc_pkg::NIRQ-1:0] sts;
    logic [gpc_pkg::NIRQ-1:0] msk;
    logic awready;
    logic wready;
    logic [5:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [18:0] p_o;
    logic [18:0] p_oe;
    logic [18:0] p_pu;
    logic [18:0] p_ttl;
    logic [18:0] p_hs;
    logic [2:0] ext_req;
    logic [2:0] port_req;
    logic irq;
  } gpc_state_type;

  gpc_state_type st_r;
  gpc_state_type st_nxt;
  logic [18:0] pin_sync;
  logic [18:0] pin_level;
  logic [18:0] pin_act_low;
  logic [18:0] pin_hit;
  logic [18:0] data_vec;
  logic [gpc_pkg::NPIN-1:0][7:0] ecfg;

  gpc_sync #(
    .WIDTH(gpc_pkg::NPIN)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .din(pad_i),
    .dout(pin_sync)
  );

  gpc_edge #(
    .WIDTH(gpc_pkg::NPIN)
  ) u_edge (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .level(pin_level),
    .act_low(pin_act_low),
    .hit(pin_hit)
  );

  // Map a register index to its configuration slot, or none
  function automatic logic [4:0] cfg_slot(input logic [5:0] idx);
    logic [4:0] s;
    s = 5'h1f;
    case (idx)
      gpc_pkg::IDX_EXT_IRQ_A_CFG: s = 5'd0;
      gpc_pkg::IDX_EXT_IRQ_B_CFG: s = 5'd1;
      gpc_pkg::IDX_EXT_IRQ_C_CFG: s = 5'd2;
      gpc_pkg::IDX_PORT1_PIN0_CFG: s = 5'd3;
      gpc_pkg::IDX_PORT1_PIN1_CFG: s = 5'd4;
      gpc_pkg::IDX_PORT1_PIN2_CFG: s = 5'd5;
      gpc_pkg::IDX_SLAVE_SELECT_CFG: s = 5'd6;
      gpc_pkg::IDX_PORT3_GROUP_CFG: s = 5'd7;
      gpc_pkg::IDX_PORT4_GROUP_CFG: s = LARGE_VARIANT ? 5'd8 : 5'h1f;
      default: s = 5'h1f;
    endcase
    return s;
  endfunction

  // Writable bits of each slot
  function automatic logic [7:0] cfg_wmask(input logic [4:0] slot);
    logic [7:0] m;
    m = gpc_pkg::WMASK_GRP;
    case (slot)
      5'd0, 5'd1, 5'd2: m = gpc_pkg::WMASK_EXT;
      5'd3: m = gpc_pkg::WMASK_P10;
      5'd4: m = gpc_pkg::WMASK_P11;
      5'd5: m = gpc_pkg::WMASK_P12;
      5'd6: m = gpc_pkg::WMASK_P13;
      default: m = gpc_pkg::WMASK_GRP;
    endcase
    return m;
  endfunction

  // Effective per-pin settings from the configuration bytes
  always_comb begin
    for (int p = 0; p < gpc_pkg::NPIN; p++) begin
      if (p < gpc_pkg::PIN_P3) begin
        ecfg[p] = st_r.cfg[p];
      end else if (p < gpc_pkg::PIN_P4) begin
        ecfg[p] = st_r.cfg[gpc_pkg::SLOT_P3];
        if (!LARGE_VARIANT && p >= gpc_pkg::PIN_P3_SMALL_END) begin
          ecfg[p] = '0;
        end
        if (!LARGE_VARIANT || p != gpc_pkg::PIN_P3_HS) begin
          ecfg[p][gpc_pkg::B_HS] = 1'b0;
        end
      end else begin
        ecfg[p] = LARGE_VARIANT ? st_r.cfg[gpc_pkg::SLOT_P4] : 8'h00;
        ecfg[p][gpc_pkg::B_HS] = 1'b0;
      end
    end
    ecfg[gpc_pkg::PIN_P1 + 1][gpc_pkg::B_PU] = st_r.cfg[gpc_pkg::SLOT_P1][gpc_pkg::B_PU];
    ecfg[gpc_pkg::PIN_SSEL][gpc_pkg::B_TTL] = 1'b1;
    // High sink exists only on slave-select and port 3 pin 7
    for (int p = 0; p < gpc_pkg::PIN_P3; p++) begin
      if (p != gpc_pkg::PIN_SSEL) begin
        ecfg[p][gpc_pkg::B_HS] = 1'b0;
      end
    end
  end

  // Port data bits in pin order
  assign data_vec = {st_r.dat[3][3:0], st_r.dat[2], st_r.dat[1][3:0], st_r.dat[0][4:2]};

  // driven pin sees its own data bit
  always_comb begin
    for (int p = 0; p < gpc_pkg::NPIN; p++) begin
      pin_level[p] = ecfg[p][gpc_pkg::B_OE] ? data_vec[p] : pin_sync[p];
      pin_act_low[p] = ecfg[p][gpc_pkg::B_ACT_LOW];
    end
  end

  // Register read mux: valid flag and byte
  function automatic logic [8:0] reg_read(input logic [5:0] idx, input gpc_state_type s);
    logic [8:0] v;
    logic [4:0] slot;
    v = 9'h000;
    slot = cfg_slot(idx);
    if (slot != 5'h1f) begin
      v = {1'b1, s.cfg[slot]};
    end else begin
      case (idx)
        gpc_pkg::IDX_PORT0_VALUE: v = {1'b1, 3'h0, pin_sync[2:0], 2'h0};
        gpc_pkg::IDX_PORT1_VALUE: v = {1'b1, 4'h0, pin_sync[6:3]};
        gpc_pkg::IDX_PORT3_VALUE: v = {1'b1, pin_sync[14:7]};
        gpc_pkg::IDX_PORT4_VALUE: v = LARGE_VARIANT ? {1'b1, 4'h0, pin_sync[18:15]} : 9'h000;
        gpc_pkg::IDX_IRQ_STATUS: v = {1'b1, 2'h0, s.sts};
        gpc_pkg::IDX_IRQ_MASK: v = {1'b1, 2'h0, s.msk};
        default: v = 9'h000;
      endcase
    end
    return v;
  endfunction

  // Next-state logic: bus slave, registers, interrupts, pads
  always_comb begin
    logic [4:0] slot;
    logic [8:0] rv;
    logic [gpc_pkg::NIRQ-1:0] ev;
    logic [gpc_pkg::NIRQ-1:0] clr;
    logic [18:0] ie;
    logic v;
    slot = 5'h1f;
    rv = 9'h000;
    ev = '0;
    clr = '0;
    ie = '0;
    v = 1'b0;
    st_nxt = st_r;

    // Write address and data channels, taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_idx = s_axi_awaddr[7:2];
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.wbyte = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
      st_nxt.wready = 1'b0;
    end

    // Perform the write once both halves are held
    if (!st_r.awready && !st_r.wready && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = gpc_pkg::RESP_OKAY;
      slot = cfg_slot(st_r.aw_idx);
      if (slot != 5'h1f) begin
        if (st_r.wlane) begin
          st_nxt.cfg[slot] = st_r.wbyte & cfg_wmask(slot);
        end
      end else begin
        case (st_r.aw_idx)
          gpc_pkg::IDX_PORT0_VALUE: if (st_r.wlane) st_nxt.dat[0] = st_r.wbyte;
          gpc_pkg::IDX_PORT1_VALUE: if (st_r.wlane) st_nxt.dat[1] = st_r.wbyte;
          gpc_pkg::IDX_PORT3_VALUE: if (st_r.wlane) st_nxt.dat[2] = st_r.wbyte;
          gpc_pkg::IDX_PORT4_VALUE: begin
            if (!LARGE_VARIANT) begin
              st_nxt.bresp = gpc_pkg::RESP_DECERR;
            end else if (st_r.wlane) begin
              st_nxt.dat[3] = st_r.wbyte;
            end
          end
          gpc_pkg::IDX_IRQ_STATUS: if (st_r.wlane) clr = st_r.wbyte[gpc_pkg::NIRQ-1:0];
          gpc_pkg::IDX_IRQ_MASK: if (st_r.wlane) st_nxt.msk = st_r.wbyte[gpc_pkg::NIRQ-1:0];
          default: st_nxt.bresp = gpc_pkg::RESP_DECERR;
        endcase
      end
    end

    // Write response handshake releases both channels
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end

    // Read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && st_r.arready) begin
      rv = reg_read(s_axi_araddr[7:2], st_r);
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rv[7:0];
      st_nxt.rresp = rv[8] ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_DECERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end

    for (int p = 0; p < gpc_pkg::NPIN; p++) begin
      ie[p] = ecfg[p][gpc_pkg::B_IE];
    end
    ev[gpc_pkg::ST_EXT +: 3] = pin_hit[2:0];
    // port pin events gated by enables
    ev[gpc_pkg::ST_P1] = |(pin_hit[6:3] & ie[6:3]);
    ev[gpc_pkg::ST_P3] = |(pin_hit[14:7] & ie[14:7]);
    ev[gpc_pkg::ST_P4] = |(pin_hit[18:15] & ie[18:15]);
    // polarity toggles land here too; set wins over clear
    st_nxt.sts = (st_r.sts & ~clr) | ev;
    st_nxt.ext_req = pin_hit[2:0] & st_r.msk[2:0];
    st_nxt.port_req = ev[5:3] & st_nxt.msk[5:3];
    st_nxt.irq = |(st_nxt.sts & st_nxt.msk);

    // pad controls follow settings in every use except clock output, which forces pad_oe on
    for (int p = 0; p < gpc_pkg::NPIN; p++) begin
      v = data_vec[p];
      // selected clock on port 1 pin 2
      if (p == gpc_pkg::PIN_CLKO && ecfg[p][gpc_pkg::B_CLKO]) begin
        v = clk_sel_i;
      end
      st_nxt.p_o[p] = v;
      st_nxt.p_oe[p] = ecfg[p][gpc_pkg::B_OE] && !(ecfg[p][gpc_pkg::B_OD] && v);
      if (p == gpc_pkg::PIN_CLKO && ecfg[p][gpc_pkg::B_CLKO]) begin
        st_nxt.p_oe[p] = 1'b1;
      end
      st_nxt.p_pu[p] = ecfg[p][gpc_pkg::B_PU];
      st_nxt.p_ttl[p] = ecfg[p][gpc_pkg::B_TTL];
      st_nxt.p_hs[p] = ecfg[p][gpc_pkg::B_HS];
    end
  end

  // state register, all zero at reset except awready, wready and arready, which reset to one
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h000000, st_r.rdata};
  assign pad_o = st_r.p_o;
  assign pad_oe = st_r.p_oe;
  assign pad_pullup = st_r.p_pu;
  assign pad_ttl = st_r.p_ttl;
  assign pad_high_sink = st_r.p_hs;
  assign ext_irq_req = st_r.ext_req;
  assign port_irq_req = st_r.port_req;
  assign irq = st_r.irq;
endmodule
`default_nettype wire

// >>> gpc_props.sv
// Checker for gpc_top: bus handshakes, pad strengths and request pulses.
// Sees only the top ports; bound below.
`timescale 1ns/10ps
`default_nettype none
module gpc_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [18:0] pad_ttl,
  input wire logic [18:0] pad_high_sink,
  input wire logic [2:0] ext_irq_req,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Transfers taken at an edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_b_latency: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off time");
  chk_r_latency: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer off time");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
    else $error("read pending but ready or wide data");
  chk_ssel_ttl: assert property ($past(arst_n, 2) |-> pad_ttl[6])
    else $error("slave select not at fixed threshold");
  chk_sink_pins: assert property ((pad_high_sink & 19'h7bfbf) == 19'h0)
    else $error("high sink on a pin without it");
  chk_req_irq: assert property (ext_irq_req != 3'h0 |-> irq)
    else $error("request without interrupt line");
  chk_req_single: assert property ((ext_irq_req & $past(ext_irq_req)) == 3'h0)
    else $error("request longer than one cycle");
endmodule
bind gpc_top gpc_props u_props (.*);
`default_nettype wire

// >>> gpc_pins.sv
// Pad model: resolves each wire from the block, the board and pull-ups.
// Undriven wires without pull-up show the inverse of their last level.
`timescale 1ns/10ps
`default_nettype none
module gpc_pins (
  input wire logic core_clk,
  input wire logic [18:0] pad_o,
  input wire logic [18:0] pad_oe,
  input wire logic [18:0] pad_pullup,
  input wire logic [18:0] drv_val,
  input wire logic [18:0] drv_en,
  output logic [18:0] pad_i
);
  logic [18:0] last_r = 19'h0;
  // Remember each wire's level
  always_ff @(posedge core_clk) begin
    last_r <= pad_i;
  end
  // Block driver first, then board, then pull-up or wander
  always_comb begin
    for (int b = 0; b < 19; b++) begin
      if (pad_oe[b]) pad_i[b] = pad_o[b];
      else if (drv_en[b]) pad_i[b] = drv_val[b];
      else pad_i[b] = pad_pullup[b] | ~last_r[b];
    end
  end
endmodule
`default_nettype wire

// >>> gpio_pin_config_ext_irq_tb.sv
// Bench for gpc_top, large variant with the pad model, small variant beside it.
// Assumes byte address four times the register index.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_config_ext_irq_tb;
  logic core_clk = 1'b0, arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clk_sel_i = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [18:0] pad_i, pad_o, pad_oe, pad_pullup, pad_ttl, pad_high_sink;
  logic [18:0] drv_val = 19'h0, drv_en = 19'h7;
  logic [2:0] ext_irq_req, port_irq_req;
  logic [31:0] rd_val;
  logic [7:0] v;
  int mismatches = 0, n_compared = 0, seed = 42964;
  int req_cnt [3] = '{0, 0, 0};
  int port_cnt = 0, pc0 = 0;
  logic [18:0] sm_oe, sm_pu, sm_hs;
  logic [5:0] cfg_idx [9] = '{6'h07, 6'h08, 6'h09, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h16, 6'h17};
  logic [7:0] wmask [9] = '{8'h37, 8'h37, 8'h37, 8'h77, 8'h65, 8'hf7, 8'h6f, 8'h7f, 8'h7f};
  always #10 core_clk = ~core_clk;
  gpc_top u_dut (.*);
  gpc_pins u_pins (.core_clk(core_clk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .drv_val(drv_val), .drv_en(drv_en), .pad_i(pad_i));
  // Small variant on the same bus and pads; only its pad settings are watched
  gpc_top #(.LARGE_VARIANT(1'b0)) u_small (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(s_axi_rready), .pad_i(pad_i), .clk_sel_i(clk_sel_i), .pad_o(), .pad_oe(sm_oe),
    .pad_pullup(sm_pu), .pad_ttl(), .pad_high_sink(sm_hs), .ext_irq_req(), .port_irq_req(), .irq());
  // Count request pulses per dedicated pin and for port 1
  always @(posedge core_clk) begin
    for (int k = 0; k < 3; k++) if (ext_irq_req[k] === 1'b1) req_cnt[k]++;
    if (port_irq_req[0] === 1'b1) port_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("BAD %0t bus gave no answer", $time);
    finish_test();
  endtask
  // Register write; returns once pads have settled
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    int dly;
    dly = {$random(seed)} % 3;
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        return;
      end
      if (n >= dly) s_axi_bready <= 1'b1;
    end
    timeout();
  endtask
  // Register read into rd_val and resp
  task automatic rd(input logic [5:0] idx);
    int dly;
    dly = {$random(seed)} % 3;
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        resp = s_axi_rresp;
        rd_val = s_axi_rdata;
        s_axi_rready <= 1'b0;
        #1;
        return;
      end
      if (n >= dly) s_axi_rready <= 1'b1;
    end
    timeout();
  endtask
  // Move one board-driven pin and count the requests it raises
  task automatic pin_edge(input int k, input logic lvl, input int exp);
    int c0;
    c0 = req_cnt[k];
    @(posedge core_clk);
    drv_val[k] <= lvl;
    repeat (6) @(posedge core_clk);
    #1;
    chk(req_cnt[k] - c0, exp);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    // Configuration bytes and mask start at zero
    for (int i = 0; i < 9; i++) begin
      rd(cfg_idx[i]);
      chk(rd_val, 32'h0);
    end
    rd(6'h31);
    chk(rd_val, 32'h0);
    chk(pad_oe, 19'h0);
    // Random bytes read back through writable bits only
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      wr(cfg_idx[i], v);
      rd(cfg_idx[i]);
      chk(rd_val, {24'h0, v & wmask[i]});
      wr(cfg_idx[i], 8'h00);
    end
    // Unmapped index gives an error and no data
    rd(6'h3f);
    chk(resp, 2'b11);
    chk(rd_val, 32'h0);
    wr(6'h3f, 8'hff);
    chk(resp, 2'b11);
    wr(6'h30, 8'h3f);
    wr(6'h31, 8'h07);
    // Each dedicated pin in both polarities
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 2; p++) begin
        pin_edge(k, p[0], p);
        wr(cfg_idx[k], p[0] ? 8'h20 : 8'h00);
        wr(6'h30, 8'h3f);
        pin_edge(k, !p[0], 1);
        rd(6'h30);
        chk(rd_val & 32'h7, 32'h1 << k);
        chk(irq, 1'b1);
        wr(6'h30, 8'h01 << k);
        chk(irq, 1'b0);
        pin_edge(k, p[0], 0);
        wr(cfg_idx[k], 8'h00);
        pin_edge(k, 1'b0, 0);
        wr(6'h30, 8'h3f);
      end
    end
    // Polarity flip alone sets status; mask gates the line
    wr(6'h31, 8'h00);
    wr(6'h07, 8'h20);
    rd(6'h30);
    chk(rd_val[0], 1'b1);
    chk(irq, 1'b0);
    wr(6'h31, 8'h01);
    chk(irq, 1'b1);
    wr(6'h30, 8'h01);
    chk(irq, 1'b0);
    wr(6'h07, 8'h00);
    // Driven dedicated pin: data write acts as the edge
    @(posedge core_clk) drv_en[2] <= 1'b0;
    wr(6'h31, 8'h07);
    wr(6'h09, 8'h01);
    wr(6'h30, 8'h3f);
    rd(6'h30);
    chk(rd_val[2], 1'b0);
    wr(6'h00, 8'h10);
    rd(6'h30);
    chk(rd_val[2], 1'b1);
    chk({pad_oe[2], pad_o[2]}, 2'b11);
    rd(6'h00);
    chk(rd_val[4], 1'b1);
    wr(6'h09, 8'h17);
    chk({pad_oe[2], pad_pullup[2], pad_ttl[2]}, 3'b011);
    @(posedge core_clk) drv_en[2] <= 1'b1;
    wr(6'h09, 8'h00);
    // Shared and group pins follow their bytes
    wr(6'h0d, 8'h02);
    chk(pad_pullup[4], 1'b1);
    @(posedge core_clk) clk_sel_i <= 1'b1;
    wr(6'h0f, 8'h80);
    chk({pad_oe[5], pad_o[5]}, 2'b11);
    @(posedge core_clk) clk_sel_i <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(pad_o[5], 1'b0);
    wr(6'h0f, 8'h00);
    chk(pad_oe[5], 1'b0);
    wr(6'h01, 8'h08);
    wr(6'h10, 8'h09);
    chk({pad_oe[6], pad_o[6], pad_high_sink[6], pad_ttl[6]}, 4'hf);
    // Slave-select edge with its enable raises one port request
    wr(6'h31, 8'h08);
    wr(6'h10, 8'h49);
    wr(6'h01, 8'h00);
    wr(6'h30, 8'h3f);
    pc0 = port_cnt;
    wr(6'h01, 8'h08);
    chk(port_cnt - pc0, 1);
    rd(6'h30);
    chk(rd_val[5:0], 6'h08);
    wr(6'h16, 8'h09);
    wr(6'h03, 8'ha5);
    chk({pad_oe[14:7], pad_o[14:7], pad_high_sink[14:7]}, 24'hffa580);
    wr(6'h17, 8'h02);
    chk(pad_pullup[18:15], 4'hf);
    // Small variant: port 3 pins 0-1 only, no port 3 sink, no port 4
    chk({sm_oe[14:7], sm_hs[14], sm_pu[18:15]}, 13'h0060);
    finish_test();
  end
endmodule
`default_nettype wire
